//--- core/ccsp_defines.svh
`ifndef CCSP_DEFINES_SVH
`define CCSP_DEFINES_SVH
// Clock period in ns (40 MHz)
`define CCSP_CLK_NS 25
// Device return delays, longest times in ns and derived cycle counts (round down)
`define CCSP_T_GATE_RET_NS 3000
`define CCSP_GATE_RET_CYC (`CCSP_T_GATE_RET_NS / `CCSP_CLK_NS)
`define CCSP_T_POLL_RET_NS 100
`define CCSP_POLL_RET_CYC (`CCSP_T_POLL_RET_NS / `CCSP_CLK_NS)
`define CCSP_T_PROP_NS 200
`define CCSP_PROP_CYC (`CCSP_T_PROP_NS / `CCSP_CLK_NS)
`define CCSP_T_FREEZE_NS 100
`define CCSP_FREEZE_CYC (`CCSP_T_FREEZE_NS / `CCSP_CLK_NS)
// Channel minimum times in ns and cycle counts (round up)
`define CCSP_T_SEL_POLL_NS 180
`define CCSP_SEL_POLL_CYC ((`CCSP_T_SEL_POLL_NS + `CCSP_CLK_NS - 1) / `CCSP_CLK_NS)
`define CCSP_T_STROBE_NS 200
`define CCSP_STROBE_CYC ((`CCSP_T_STROBE_NS + `CCSP_CLK_NS - 1) / `CCSP_CLK_NS)
`define CCSP_T_QUIET_NS 100
`define CCSP_QUIET_CYC ((`CCSP_T_QUIET_NS + `CCSP_CLK_NS - 1) / `CCSP_CLK_NS)
// Bus widths
`define CCSP_ADDR_W 16
`define CCSP_DATA_W 16
`define CCSP_STAT_W 8
`define CCSP_LEVEL_W 2
`define CCSP_REQ_W 4
// Status bus error bit position
`define CCSP_STAT_ERR_BIT 0
// Channel sequence timeout in cycles
`define CCSP_SEQ_TIMEOUT_CYC 400
`endif

//--- core/ccsp_pkg.sv
package ccsp_pkg;
	// Request class carried on the selector lines
	typedef enum logic [1:0] {
		CCSP_CLS_NONE,
		CCSP_CLS_INTR,
		CCSP_CLS_CSTEAL
	} ccsp_class_type;
endpackage

//--- core/ccsp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_defines.svh"
interface ccsp_link_if;
	// Service group
	logic service_gate;
	logic data_strobe;
	logic service_gate_return;
	logic [`CCSP_ADDR_W-1:0] addr_bus;
	logic cycle_byte;
	logic cycle_input;
	logic [`CCSP_DATA_W-1:0] data_in_bus;
	logic [`CCSP_DATA_W-1:0] data_out_bus;
	logic data_out_parity;
	logic [`CCSP_STAT_W-1:0] status_bus;
	logic [`CCSP_STAT_W-1:0] cond_code_in;
	// Poll group
	logic [1:0] request_class_selector;
	logic poll;
	logic poll_return;
	logic burst_return;
	logic poll_propagate;
	logic [`CCSP_REQ_W-1:0] intr_request;
	logic cycle_steal_request;
	// Resets
	logic machine_check_halt;
	logic system_reset;
	logic device_reset;
	modport device (
		input service_gate, data_strobe, data_out_bus, data_out_parity, status_bus,
		input request_class_selector, poll, machine_check_halt, system_reset, device_reset,
		output service_gate_return, addr_bus, cycle_byte, cycle_input, data_in_bus, cond_code_in,
		output poll_return, burst_return, poll_propagate, intr_request, cycle_steal_request
	);
	modport channel (
		output service_gate, data_strobe, data_out_bus, data_out_parity, status_bus,
		output request_class_selector, poll, machine_check_halt, system_reset, device_reset,
		input service_gate_return, addr_bus, cycle_byte, cycle_input, data_in_bus, cond_code_in,
		input poll_return, burst_return, poll_propagate, intr_request, cycle_steal_request
	);
endinterface
`default_nettype wire

//--- core/ccsp_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_defines.svh"
module ccsp_device
	import ccsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	ccsp_link_if.device link,
	input wire logic cs_req_i,
	input wire logic cs_input_i,
	input wire logic cs_byte_i,
	input wire logic cs_burst_i,
	input wire logic [7:0] cs_count_i,
	input wire logic [`CCSP_ADDR_W-1:0] cs_addr_i,
	input wire logic [`CCSP_DATA_W-1:0] cs_wdata_i,
	input wire logic intr_cond_i,
	input wire logic intr_mask_i,
	input wire logic [`CCSP_LEVEL_W-1:0] intr_level_i,
	output logic cs_busy_o,
	output logic xfer_done_o,
	output logic [`CCSP_DATA_W-1:0] xfer_rdata_o,
	output logic [`CCSP_STAT_W-1:0] xfer_status_o,
	output logic parity_err_o,
	output logic dummy_o,
	output logic intr_served_o
);
	typedef enum logic [2:0] {
		CCSP_IDLE,
		CCSP_WAIT_GATE,
		CCSP_DRIVE,
		CCSP_STROBE,
		CCSP_RELEASE,
		CCSP_DROP
	} ccsp_svc_type;

	// Three-stage synchronisers; stages 2 and 3 must agree
	logic [2:0] gate_s, strobe_s, poll_s, halt_s, sysr_s, devr_s;
	logic [1:0] sel_s1, sel_s2, sel_s3;
	logic gate_reg, strobe_reg, poll_reg, halt_reg, sysr_reg, devr_reg;
	logic [1:0] sel_reg;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			gate_s <= 3'h0;
			strobe_s <= 3'h0;
			poll_s <= 3'h0;
			halt_s <= 3'h0;
			sysr_s <= 3'h0;
			devr_s <= 3'h0;
			sel_s1 <= 2'h0;
			sel_s2 <= 2'h0;
			sel_s3 <= 2'h0;
		end else begin
			gate_s <= {gate_s[1:0], link.service_gate};
			strobe_s <= {strobe_s[1:0], link.data_strobe};
			poll_s <= {poll_s[1:0], link.poll};
			halt_s <= {halt_s[1:0], link.machine_check_halt};
			sysr_s <= {sysr_s[1:0], link.system_reset};
			devr_s <= {devr_s[1:0], link.device_reset};
			sel_s1 <= link.request_class_selector;
			sel_s2 <= sel_s1;
			sel_s3 <= sel_s2;
		end
	end
	// Filtered levels change only when stages 2 and 3 agree
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			gate_reg <= 1'b0;
			strobe_reg <= 1'b0;
			poll_reg <= 1'b0;
			halt_reg <= 1'b0;
			sysr_reg <= 1'b0;
			devr_reg <= 1'b0;
			sel_reg <= 2'h0;
		end else begin
			if (gate_s[1] == gate_s[2]) gate_reg <= gate_s[2];
			if (strobe_s[1] == strobe_s[2]) strobe_reg <= strobe_s[2];
			if (poll_s[1] == poll_s[2]) poll_reg <= poll_s[2];
			if (halt_s[1] == halt_s[2]) halt_reg <= halt_s[2];
			if (sysr_s[1] == sysr_s[2]) sysr_reg <= sysr_s[2];
			if (devr_s[1] == devr_s[2]) devr_reg <= devr_s[2];
			if (sel_s2 == sel_s3) sel_reg <= sel_s3;
		end
	end

	logic gate_prev_reg, poll_prev_reg, sel_prev_reg;
	logic gate_rise, poll_rise, poll_fall, sel_act;
	logic hard_reset;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			gate_prev_reg <= 1'b0;
			poll_prev_reg <= 1'b0;
			sel_prev_reg <= 1'b0;
		end else begin
			gate_prev_reg <= gate_reg;
			poll_prev_reg <= poll_reg;
			sel_prev_reg <= (sel_reg != 2'h0);
		end
	end
	assign gate_rise = gate_reg & ~gate_prev_reg;
	assign poll_rise = poll_reg & ~poll_prev_reg;
	assign poll_fall = ~poll_reg & poll_prev_reg;
	assign sel_act = (sel_reg != 2'h0) & ~sel_prev_reg;
	assign hard_reset = halt_reg | sysr_reg;

	// Request state and frozen snapshot for the poll decision
	logic csr_reg, irq_reg, frz_cs_reg, frz_irq_reg;
	logic [`CCSP_LEVEL_W-1:0] frz_level_reg;
	logic captured_reg, cap_burst_reg, cap_intr_reg, pollret_reg, burstret_reg, prop_reg;
	logic svc_done;
	ccsp_svc_type state_reg;
	logic [7:0] left_reg;
	logic dummy_reg, devr_pend_reg, last_xfer;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			frz_cs_reg <= 1'b0;
			frz_irq_reg <= 1'b0;
			frz_level_reg <= '0;
		end else if (sel_act) begin
			frz_cs_reg <= csr_reg;
			frz_irq_reg <= irq_reg;
			frz_level_reg <= intr_level_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || hard_reset)
			csr_reg <= 1'b0;
		else if (poll_rise && sel_reg == CCSP_CLS_CSTEAL && frz_cs_reg)
			csr_reg <= 1'b0;
		// no new request until return falls
		else if (cs_req_i && !captured_reg && state_reg == CCSP_IDLE && !pollret_reg)
			csr_reg <= 1'b1;
	end

	// masked interrupt request; held until cleared
	always_ff @(posedge clk_i) begin
		if (reset_i || hard_reset || devr_reg || !intr_mask_i)
			irq_reg <= 1'b0;
		else if (poll_rise && sel_reg == CCSP_CLS_INTR && frz_irq_reg)
			irq_reg <= 1'b0;
		else if (intr_cond_i && !captured_reg && state_reg == CCSP_IDLE && !burstret_reg)
			irq_reg <= 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || hard_reset) begin
			captured_reg <= 1'b0;
			cap_burst_reg <= 1'b0;
			cap_intr_reg <= 1'b0;
			pollret_reg <= 1'b0;
			burstret_reg <= 1'b0;
			prop_reg <= 1'b0;
		end else begin
			if (poll_rise && ((sel_reg == CCSP_CLS_CSTEAL && frz_cs_reg) ||
					(sel_reg == CCSP_CLS_INTR && frz_irq_reg))) begin
				captured_reg <= 1'b1;
				cap_intr_reg <= (sel_reg == CCSP_CLS_INTR);
				cap_burst_reg <= (sel_reg == CCSP_CLS_CSTEAL) && cs_burst_i;
				pollret_reg <= !((sel_reg == CCSP_CLS_CSTEAL) && cs_burst_i);
				burstret_reg <= (sel_reg == CCSP_CLS_CSTEAL) && cs_burst_i;
			end else if (poll_rise)
				prop_reg <= 1'b1;
			if (!poll_reg)
				prop_reg <= 1'b0;
			if (poll_fall)
				pollret_reg <= 1'b0;
			// burst return drops at final gate
			if (gate_rise && burstret_reg && last_xfer)
				burstret_reg <= 1'b0;
			if (svc_done && !burstret_reg)
				captured_reg <= 1'b0;
			// Interrupt service is not run here, so an interrupt capture ends with poll
			if (poll_fall && cap_intr_reg)
				captured_reg <= 1'b0;
		end
	end

	assign last_xfer = (left_reg == 8'h01) || dummy_reg || devr_pend_reg;
	assign svc_done = (state_reg == CCSP_DROP);

	// Transfer counter, dummy tracking, device-reset pending
	logic [`CCSP_STAT_W-1:0] stat_hold_reg;
	logic err_now;
	assign err_now = strobe_reg && stat_hold_reg[`CCSP_STAT_ERR_BIT];
	always_ff @(posedge clk_i) begin
		if (reset_i || hard_reset) begin
			left_reg <= 8'h00;
			dummy_reg <= 1'b0;
			devr_pend_reg <= 1'b0;
		end else begin
			if (cs_req_i && state_reg == CCSP_IDLE && !captured_reg)
				left_reg <= cs_burst_i ? cs_count_i : 8'h01;
			// reset while pending becomes dummy read
			if (devr_reg && (csr_reg || captured_reg))
				devr_pend_reg <= 1'b1;
			if (state_reg == CCSP_RELEASE && cap_burst_reg && !last_xfer && stat_hold_reg[`CCSP_STAT_ERR_BIT])
				dummy_reg <= 1'b1;
			if (svc_done && !gate_reg) begin
				left_reg <= left_reg - 8'h01;
				if (last_xfer && !burstret_reg) begin
					dummy_reg <= 1'b0;
					devr_pend_reg <= 1'b0;
				end
			end
		end
	end

	// service state machine; burst gates back to back
	logic [7:0] dly_reg;
	always_ff @(posedge clk_i) begin
		if (reset_i || hard_reset) begin
			state_reg <= CCSP_IDLE;
			dly_reg <= 8'h00;
		end else begin
			case (state_reg)
				CCSP_IDLE: if (captured_reg && !cap_intr_reg) state_reg <= CCSP_WAIT_GATE;
				CCSP_WAIT_GATE: if (gate_rise) state_reg <= CCSP_DRIVE;
				// return raised next cycle, well inside limit
				CCSP_DRIVE: state_reg <= CCSP_STROBE;
				CCSP_STROBE: if (!gate_reg && !strobe_reg) state_reg <= CCSP_RELEASE;
				// buses released one cycle before return drops
				CCSP_RELEASE: state_reg <= CCSP_DROP;
				CCSP_DROP: state_reg <= burstret_reg ? CCSP_WAIT_GATE : CCSP_IDLE;
				default: state_reg <= CCSP_IDLE;
			endcase
			dly_reg <= (state_reg == CCSP_STROBE) ? dly_reg + 8'h01 : 8'h00;
		end
	end

	// sample late in strobe, one cycle after sync settles
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			stat_hold_reg <= '0;
			xfer_rdata_o <= '0;
			xfer_status_o <= '0;
			parity_err_o <= 1'b0;
		end else if (cs_req_i && state_reg == CCSP_IDLE && !captured_reg) begin
			// Status gathers per request, so a new request starts clean
			xfer_status_o <= '0;
		end else if (state_reg == CCSP_STROBE && strobe_reg) begin
			stat_hold_reg <= link.status_bus;
			// dummy cycle keeps parameters and status
			if (!dummy_reg && !devr_pend_reg) begin
				xfer_status_o <= xfer_status_o | link.status_bus;
				if (!link.cycle_input)
					xfer_rdata_o <= link.data_out_bus;
				parity_err_o <= !link.cycle_input && (^link.data_out_bus == link.data_out_parity);
			end
		end
	end

	// Completion pulses
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			xfer_done_o <= 1'b0;
			intr_served_o <= 1'b0;
		end else begin
			xfer_done_o <= (state_reg == CCSP_RELEASE) && !dummy_reg && !devr_pend_reg;
			intr_served_o <= poll_rise && sel_reg == CCSP_CLS_INTR && frz_irq_reg;
		end
	end

	// drive outputs from gate rise to release
	logic drive;
	assign drive = (state_reg == CCSP_DRIVE) || (state_reg == CCSP_STROBE);
	assign link.addr_bus = drive ? cs_addr_i : '0;
	assign link.cycle_byte = drive && cs_byte_i;
	assign link.cycle_input = drive && cs_input_i && !dummy_reg && !devr_pend_reg;
	assign link.data_in_bus = (drive && link.cycle_input) ? cs_wdata_i : '0;
	assign link.cond_code_in = '0;
	assign link.service_gate_return = (state_reg == CCSP_STROBE) || (state_reg == CCSP_RELEASE);
	assign link.poll_return = pollret_reg;
	assign link.burst_return = burstret_reg;
	assign link.poll_propagate = prop_reg && poll_reg;
	assign link.intr_request = irq_reg ? (`CCSP_REQ_W'(1) << intr_level_i) : '0;
	assign link.cycle_steal_request = csr_reg;
	assign cs_busy_o = csr_reg || captured_reg || (state_reg != CCSP_IDLE);
	assign dummy_o = dummy_reg || devr_pend_reg;
endmodule
`default_nettype wire

//--- core/ccsp_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_defines.svh"
module ccsp_channel
	import ccsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	ccsp_link_if.channel link,
	input wire logic sys_reset_i,
	input wire logic dev_reset_i,
	input wire logic [`CCSP_STAT_W-1:0] status_i,
	input wire logic [`CCSP_DATA_W-1:0] wdata_i,
	output logic [`CCSP_ADDR_W-1:0] addr_o,
	output logic [`CCSP_DATA_W-1:0] rdata_o,
	output logic xfer_o,
	output logic intr_ack_o
);
	typedef enum logic [3:0] {
		CH_IDLE, CH_SEL, CH_POLL, CH_QUIET, CH_GATE, CH_STROBE, CH_WAIT_DROP, CH_FAULT
	} ch_state_type;
	ch_state_type st_reg;
	logic [8:0] cnt_reg;
	logic [8:0] tmo_reg;
	logic burst_reg, intr_reg;
	logic [1:0] cls_reg;
	// selector, poll, quiet; strobe; drop together
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= CH_IDLE;
			cnt_reg <= 9'h000;
			burst_reg <= 1'b0;
			intr_reg <= 1'b0;
			cls_reg <= 2'h0;
		end else begin
			cnt_reg <= cnt_reg + 9'h001;
			case (st_reg)
				CH_IDLE: begin
					cnt_reg <= 9'h000;
					if (link.cycle_steal_request) begin
						cls_reg <= CCSP_CLS_CSTEAL;
						st_reg <= CH_SEL;
					end else if (link.intr_request != '0) begin
						cls_reg <= CCSP_CLS_INTR;
						st_reg <= CH_SEL;
					end
				end
				CH_SEL: if (cnt_reg >= 9'(`CCSP_SEL_POLL_CYC)) begin
					st_reg <= CH_POLL;
					cnt_reg <= 9'h000;
				end
				CH_POLL: if (link.poll_return || link.burst_return) begin
					burst_reg <= link.burst_return;
					intr_reg <= (cls_reg == CCSP_CLS_INTR);
					st_reg <= CH_QUIET;
					cnt_reg <= 9'h000;
				end else if (cnt_reg == 9'(`CCSP_SEQ_TIMEOUT_CYC)) st_reg <= CH_FAULT;
				CH_QUIET: if (cnt_reg >= 9'(`CCSP_QUIET_CYC) && !link.poll_return) begin
					st_reg <= intr_reg ? CH_IDLE : CH_GATE;
					cnt_reg <= 9'h000;
				end
				CH_GATE: if (link.service_gate_return) begin
					st_reg <= CH_STROBE;
					cnt_reg <= 9'h000;
				end
				CH_STROBE: if (cnt_reg >= 9'(`CCSP_STROBE_CYC)) begin
					st_reg <= CH_WAIT_DROP;
					cnt_reg <= 9'h000;
				end
				CH_WAIT_DROP: if (!link.service_gate_return) begin
					st_reg <= (burst_reg && link.burst_return) ? CH_GATE : CH_IDLE;
					cnt_reg <= 9'h000;
				end
				CH_FAULT: st_reg <= CH_IDLE;
				default: st_reg <= CH_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i || st_reg == CH_IDLE || st_reg == CH_POLL)
			tmo_reg <= 9'h000;
		else if (st_reg >= CH_GATE && tmo_reg != 9'h1ff)
			tmo_reg <= tmo_reg + 9'h001;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			addr_o <= '0;
			rdata_o <= '0;
			xfer_o <= 1'b0;
			intr_ack_o <= 1'b0;
		end else begin
			xfer_o <= st_reg == CH_STROBE && cnt_reg == 9'h000;
			intr_ack_o <= st_reg == CH_QUIET && cnt_reg == 9'h000 && intr_reg;
			if (st_reg == CH_STROBE && cnt_reg == 9'h000) begin
				addr_o <= link.addr_bus;
				rdata_o <= link.data_in_bus;
			end
		end
	end
	assign link.request_class_selector = (st_reg == CH_SEL || st_reg == CH_POLL) ? cls_reg : 2'h0;
	assign link.poll = st_reg == CH_POLL;
	assign link.service_gate = st_reg == CH_GATE || st_reg == CH_STROBE;
	assign link.data_strobe = st_reg == CH_STROBE;
	assign link.status_bus = status_i;
	assign link.data_out_bus = wdata_i;
	assign link.data_out_parity = ~^wdata_i;
	assign link.machine_check_halt = st_reg == CH_FAULT || tmo_reg == 9'(`CCSP_SEQ_TIMEOUT_CYC);
	assign link.system_reset = sys_reset_i;
	assign link.device_reset = dev_reset_i;
endmodule
`default_nettype wire

//--- tb/ccsp_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_defines.svh"
module ccsp_link_checker
	import ccsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic service_gate,
	input wire logic data_strobe,
	input wire logic service_gate_return,
	input wire logic [`CCSP_ADDR_W-1:0] addr_bus,
	input wire logic cycle_byte,
	input wire logic cycle_input,
	input wire logic [`CCSP_DATA_W-1:0] data_in_bus,
	input wire logic [`CCSP_STAT_W-1:0] cond_code_in,
	input wire logic [1:0] request_class_selector,
	input wire logic poll,
	input wire logic poll_return,
	input wire logic burst_return,
	input wire logic poll_propagate,
	input wire logic [`CCSP_REQ_W-1:0] intr_request,
	input wire logic cycle_steal_request,
	input wire logic machine_check_halt,
	input wire logic system_reset
);
	// Device delay ceilings in cycles; poll answers share the propagate bound
	localparam int RET_LIMIT = `CCSP_GATE_RET_CYC;
	localparam int POLL_LIMIT = `CCSP_PROP_CYC;
	// Cycles since a halt or system reset, so a request may drop soon after one
	logic [3:0] since_rst_reg;
	always_ff @(posedge clk_i) begin
		if (reset_i || system_reset || machine_check_halt) begin
			since_rst_reg <= 4'h0;
		end else if (since_rst_reg != 4'hf) begin
			since_rst_reg <= since_rst_reg + 4'h1;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	a_gate_ret_bound: assert property ($rose(service_gate) |-> ##[1:RET_LIMIT] service_gate_return)
		else $error("gate return late");
	a_ret_drop_bound: assert property ($fell(service_gate) |-> ##[0:RET_LIMIT] !service_gate_return)
		else $error("gate return held too long");
	a_bus_stable: assert property (service_gate_return && $past(service_gate_return) && (service_gate || data_strobe)
		|-> $stable(addr_bus) && $stable(cycle_byte) && $stable(cycle_input) && $stable(data_in_bus))
		else $error("device buses moved during transfer");
	a_release_first: assert property ($fell(service_gate_return) |-> addr_bus == '0 && !cycle_byte
		&& !cycle_input && data_in_bus == '0 && cond_code_in == '0)
		else $error("buses not released before return drop");
	a_poll_answer: assert property ($rose(poll) |-> ##[1:POLL_LIMIT] (poll_return || burst_return || poll_propagate))
		else $error("no answer to poll");
	a_csr_drop_first: assert property ($rose(poll_return || burst_return)
		&& request_class_selector == CCSP_CLS_CSTEAL |-> !cycle_steal_request)
		else $error("steal request still up at capture");
	a_intr_drop_first: assert property ($rose(poll_return) && request_class_selector == CCSP_CLS_INTR
		|-> intr_request == '0)
		else $error("interrupt request still up at capture");
	a_poll_ret_drop: assert property ($fell(poll) |-> ##[0:POLL_LIMIT] !poll_return)
		else $error("poll return held after poll");
	a_prop_rise: assert property ($rose(poll_propagate) |-> poll)
		else $error("propagate without poll");
	a_reset_quiet: assert property (system_reset [*6] |-> !poll_propagate && !cycle_steal_request
		&& intr_request == '0 && !poll_return && !burst_return)
		else $error("request lines up during system reset");
	a_csr_hold: assert property ($fell(cycle_steal_request) |-> poll || since_rst_reg < 4'ha)
		else $error("steal request dropped uncaptured");
	a_burst_drop: assert property ($fell(burst_return) |-> service_gate || since_rst_reg < 4'ha)
		else $error("burst return dropped outside gate");
	// Main scenarios reached
	c_burst: cover property ($rose(burst_return));
	c_intr: cover property ($rose(poll_return) && request_class_selector == CCSP_CLS_INTR);
	c_input: cover property ($rose(service_gate_return) && cycle_input);
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_defines.svh"
module testbench;
	typedef struct packed {
		logic inp;
		logic byt;
		logic [15:0] addr;
		logic [15:0] data;
		logic [7:0] stat;
	} ccsp_row_type;
	// Byte rows keep the upper byte clear so any byte lane convention gives one word
	localparam ccsp_row_type ROWS [6] = '{'{1'b0, 1'b0, 16'h1234, 16'h5a3c, 8'h00},
		'{1'b1, 1'b0, 16'hffff, 16'ha5c3, 8'h80}, '{1'b0, 1'b1, 16'h0000, 16'h00ff, 8'h40},
		'{1'b1, 1'b1, 16'h8001, 16'h0081, 8'h00}, '{1'b1, 1'b0, 16'h0001, 16'hffff, 8'h02},
		'{1'b0, 1'b0, 16'h7ffe, 16'h0000, 8'h00}};
	logic clk_i, reset_i, cs_req_i, cs_input_i, cs_byte_i, cs_burst_i, intr_cond_i, intr_mask_i;
	logic [7:0] cs_count_i, status_i, xfer_status_o, d_stat;
	logic [15:0] cs_addr_i, cs_wdata_i, wdata_i, xfer_rdata_o, addr_o, rdata_o, d_rdata, c_addr, c_rdata;
	logic [1:0] intr_level_i;
	logic cs_busy_o, xfer_done_o, parity_err_o, dummy_o, intr_served_o, sys_reset_i, dev_reset_i, xfer_o, intr_ack_o;
	logic got_dummy, seen_byte, seen_inp, seen_intr, bad_wire;
	int n_fail, num_checks, cyc, n_done, n_xfer, n_served, n_ack, k;
	ccsp_link_if link();
	ccsp_device ccsp_device_i (.clk_i(clk_i), .reset_i(reset_i), .link(link), .cs_req_i(cs_req_i),
		.cs_input_i(cs_input_i), .cs_byte_i(cs_byte_i), .cs_burst_i(cs_burst_i), .cs_count_i(cs_count_i),
		.cs_addr_i(cs_addr_i), .cs_wdata_i(cs_wdata_i), .intr_cond_i(intr_cond_i), .intr_mask_i(intr_mask_i),
		.intr_level_i(intr_level_i), .cs_busy_o(cs_busy_o), .xfer_done_o(xfer_done_o), .xfer_rdata_o(xfer_rdata_o),
		.xfer_status_o(xfer_status_o), .parity_err_o(parity_err_o), .dummy_o(dummy_o), .intr_served_o(intr_served_o));
	ccsp_channel ccsp_channel_i (.clk_i(clk_i), .reset_i(reset_i), .link(link), .sys_reset_i(sys_reset_i),
		.dev_reset_i(dev_reset_i), .status_i(status_i), .wdata_i(wdata_i), .addr_o(addr_o), .rdata_o(rdata_o),
		.xfer_o(xfer_o), .intr_ack_o(intr_ack_o));
	ccsp_link_checker ccsp_link_checker_i (.clk_i(clk_i), .reset_i(reset_i), .service_gate(link.service_gate),
		.data_strobe(link.data_strobe), .service_gate_return(link.service_gate_return), .addr_bus(link.addr_bus),
		.cycle_byte(link.cycle_byte), .cycle_input(link.cycle_input), .data_in_bus(link.data_in_bus),
		.cond_code_in(link.cond_code_in), .request_class_selector(link.request_class_selector), .poll(link.poll),
		.poll_return(link.poll_return), .burst_return(link.burst_return), .poll_propagate(link.poll_propagate),
		.intr_request(link.intr_request), .cycle_steal_request(link.cycle_steal_request),
		.machine_check_halt(link.machine_check_halt), .system_reset(link.system_reset));
	// 40 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic complete_run();
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp, input string what);
		chk_word({15'h0000, got}, {15'h0000, exp}, what);
	endtask
	task automatic chk_count(input int got, input int exp, input string what);
		chk_word(got[15:0], exp[15:0], what);
	endtask
	task automatic step();
		@(posedge clk_i);
		#2;
	endtask
	// Tally pulses and wire events at the edge, before that edge's own updates land
	always @(posedge clk_i) begin
		cyc++;
		if (xfer_done_o === 1'b1) begin
			n_done++;
			d_rdata = xfer_rdata_o;
			d_stat = xfer_status_o;
		end
		if (xfer_o === 1'b1) begin
			n_xfer++;
			c_addr = addr_o;
			c_rdata = rdata_o;
		end
		n_served += (intr_served_o === 1'b1);
		n_ack += (intr_ack_o === 1'b1);
		got_dummy |= (dummy_o === 1'b1);
		seen_byte |= (link.service_gate_return === 1'b1 && link.cycle_byte === 1'b1);
		seen_inp |= (link.service_gate_return === 1'b1 && link.cycle_input === 1'b1);
		seen_intr |= (link.intr_request !== 4'h0);
		// Odd parity on outbound words, and strobe never alone without gate
		bad_wire |= (link.data_strobe === 1'b1 && link.cycle_input === 1'b0
			&& ^{link.data_out_bus, link.data_out_parity} !== 1'b1) || (link.data_strobe === 1'b1 && link.service_gate !== 1'b1);
		// Ceiling well above the thousand or so cycles the sequence needs
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	// One request; withdrawn once busy shows, with an optional device reset pulse at cycle rst_at
	task automatic run_steal(input logic inp, input logic byt, input logic bst, input logic [7:0] cnt,
		input logic [15:0] addr, input logic [15:0] data, input logic [7:0] stat, input int rst_at);
		{cs_input_i, cs_byte_i, cs_burst_i, cs_count_i, cs_addr_i, cs_wdata_i} = {inp, byt, bst, cnt, addr, data};
		wdata_i = data;
		status_i = stat;
		{n_done, n_xfer, got_dummy, seen_byte, seen_inp} = '0;
		cs_req_i = 1'b1;
		for (k = 0; k < 2000 && !(n_done + n_xfer > 0 && cs_busy_o === 1'b0); k++) begin
			step();
			if (cs_busy_o === 1'b1) cs_req_i = 1'b0;
			dev_reset_i = (k >= rst_at && k < rst_at + 3);
		end
		chk_flag(k < 2000, 1'b1, "steal end");
		repeat (12) step();
	endtask
	initial begin
		{cs_req_i, cs_input_i, cs_byte_i, cs_burst_i, intr_cond_i, intr_mask_i, sys_reset_i, dev_reset_i} = '0;
		{cs_count_i, status_i, cs_addr_i, cs_wdata_i, wdata_i, intr_level_i} = '0;
		{n_fail, num_checks, cyc, n_served, n_ack, seen_intr, bad_wire} = '0;
		reset_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#2 reset_i = 1'b0;
		chk_word({cs_busy_o, link.cycle_steal_request, link.intr_request, link.service_gate_return}, 16'h0000, "reset");
		foreach (ROWS[i]) begin
			run_steal(ROWS[i].inp, ROWS[i].byt, 1'b0, 8'h01, ROWS[i].addr, ROWS[i].data, ROWS[i].stat, -10);
			chk_count(n_xfer + n_done, 2, "one transfer");
			chk_word(c_addr, ROWS[i].addr, "address");
			chk_word(ROWS[i].inp ? c_rdata : d_rdata, ROWS[i].data, "data");
			chk_word({8'h00, d_stat}, {8'h00, ROWS[i].stat}, "status");
			chk_flag(seen_byte, ROWS[i].byt, "byte flag");
			chk_flag(seen_inp, ROWS[i].inp, "input flag");
			chk_flag(parity_err_o, 1'b0, "parity");
		end
		// Clean burst, error on first of three, error on a lone final word
		run_steal(1'b1, 1'b0, 1'b1, 8'h03, 16'h0100, 16'h1111, 8'h00, -10);
		chk_word({n_xfer[7:0], n_done[7:0]}, 16'h0303, "burst count");
		chk_flag(got_dummy, 1'b0, "no dummy");
		run_steal(1'b0, 1'b0, 1'b1, 8'h03, 16'h0200, 16'h2222, 8'h01, -10);
		chk_word({n_xfer[7:0], n_done[7:0]}, 16'h0201, "error burst");
		chk_flag(got_dummy, 1'b1, "dummy after error");
		run_steal(1'b0, 1'b0, 1'b1, 8'h01, 16'h0300, 16'h3333, 8'h01, -10);
		chk_word({7'h00, n_xfer[7:0], got_dummy}, 16'h0002, "error on last");
		// Device reset while the input request is pending turns it into a dummy read
		run_steal(1'b1, 1'b0, 1'b0, 8'h01, 16'h0400, 16'h4444, 8'h00, 6);
		chk_word({n_xfer[7:0], n_done[3:0], got_dummy, seen_inp, 2'b00}, 16'h0108, "reset dummy");
		// A masked condition must stay off the request bus
		intr_cond_i = 1'b1;
		repeat (40) step();
		chk_flag(seen_intr, 1'b0, "masked request");
		for (int lv = 0; lv < 4; lv++) begin
			{n_served, n_ack} = '0;
			intr_level_i = 2'(lv);
			intr_mask_i = 1'b1;
			for (k = 0; k < 100 && link.intr_request === 4'h0; k++) step();
			chk_word(16'(link.intr_request), 16'h0001 << lv, "request bit");
			for (k = 0; k < 100 && link.intr_request !== 4'h0; k++) step();
			intr_cond_i = 1'b0;
			repeat (20) step();
			chk_word({n_served[7:0], n_ack[7:0]}, 16'h0101, "capture");
			chk_word(16'(link.intr_request), 16'h0000, "request dropped");
			intr_cond_i = lv < 3;
		end
		// System reset clears the request and service state, then a transfer works again
		sys_reset_i = 1'b1;
		repeat (10) step();
		sys_reset_i = 1'b0;
		chk_flag(cs_busy_o, 1'b0, "idle after reset");
		run_steal(1'b0, 1'b1, 1'b0, 8'h01, 16'h5555, 16'h0055, 8'h00, -10);
		chk_word(d_rdata, 16'h0055, "after reset");
		chk_flag(bad_wire, 1'b0, "wire parity and strobe");
		complete_run();
	end
endmodule
`default_nettype wire
